// ---- core/agr_pkg.sv ----
// Constants for the group one result FIFO read block.
// Assumes a 32-bit Avalon-MM slave with byte addresses and a 40 MHz clock.
package agr_pkg;
   // Byte offsets of the read ports and the control and interrupt registers
   localparam logic [7:0] POP_LO = 8'h20;     // First alias of the popping port
   localparam logic [7:0] POP_HI = 8'h3f;     // Last byte of the alias range
   localparam logic [7:0] PEEK_OFS = 8'h94;   // Non-popping view
   localparam logic [7:0] CTRL_OFS = 8'h98;   // Mode control
   localparam logic [7:0] IRQ_STAT_OFS = 8'h9c;  // Sticky events
   localparam logic [7:0] IRQ_EN_OFS = 8'ha0;    // Event enables
   localparam logic [7:0] IRQ_CLR_OFS = 8'ha4;   // Write one to clear
   // Result word layout
   localparam int EMPTY_BIT = 15;             // Empty flag
   localparam int TAG_LSB = 10;               // Channel tag low bit
   localparam int RES_W = 10;                 // Full result width
   localparam int TAG_W = 4;                  // Channel tag width
   localparam int SHIFT8 = 2;                 // Eight-bit mode drops two LSBs
   // Control register fields
   localparam int CTRL_BUF = 0;               // Buffered mode
   localparam int CTRL_8BIT = 1;              // Eight-bit result mode
   localparam int CTRL_TAG = 2;               // Channel tag enable
   localparam int CTRL_W = 3;
   localparam logic [2:0] CTRL_RST = 3'h1;    // Buffered mode after reset
   // Interrupt event bits
   localparam int EV_POP = 0;                 // An entry was popped
   localparam int EV_UNDER = 1;               // Pop attempted while empty/overrun
   localparam int EV_W = 2;
endpackage

// ---- core/agr_result_fifo.sv ----
// Group one result FIFO: write side for the sequencer, read ports for software.
// Assumes the sequencer drives wr_valid only while wr_ready is high.
//
// Overview of operation
// [RQ1] Default result reads full ten bits
// [RQ2] Eight-bit mode: upper bits zero, MSBs low
// [RQ3] Eight-bit shift applied at read time
// [RQ4] Valid pop-port read advances output pointer
// [RQ5] Empty or overrun read leaves pointer alone
// [RQ6] Suspend blocks every pop-port state change
// [RQ7] Words 0x20 to 0x3F decode as pop
// [RQ8] Each alias read pops one, in order
// [RQ9] Peek view exists only in buffered mode
// [RQ10] Bit 15 empty flag, one after reset
// [RQ11] Bit 14 always reads zero
// [RQ12] Tag bits zero unless tagging enabled
// [RQ13] Tag is unsigned four-bit channel number
// [RQ14] Tags 1110/1111 mean channels fourteen/fifteen
// [RQ15] Peek returns head without moving pointer
// [RQ16] Peek and pop format head identically
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module agr_result_fifo #(
   parameter int DEPTH = 16,   // Entries held
   parameter int AW = 4        // Pointer width, log2 of DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Avalon-MM slave
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Sequencer write side
   input wire logic wr_valid,
   input wire logic [9:0] wr_result,
   input wire logic [3:0] wr_channel,
   output logic wr_ready,
   // Status from the rest of the converter
   input wire logic overrun,
   input wire logic suspend,
   // Interrupt
   output logic irq
);
   // Storage, one entry = tag plus result
   logic [agr_pkg::RES_W-1:0] res_mem [DEPTH];
   logic [agr_pkg::TAG_W-1:0] tag_mem [DEPTH];
   logic [AW-1:0] rd_ptr_r;          // Output pointer
   logic [AW-1:0] wr_ptr_r;          // Input pointer
   logic [AW:0] count_r;             // Entries held
   logic [agr_pkg::CTRL_W-1:0] ctrl_r;
   logic [agr_pkg::EV_W-1:0] stat_r;
   logic [agr_pkg::EV_W-1:0] en_r;
   logic ack_r;                      // One wait state per access
   logic [31:0] rdata_r;
   logic empty;
   logic push;
   logic hit_pop;
   logic hit_peek;
   logic pop;
   logic pop_bad;
   logic [15:0] head_word;
   logic [31:0] rdata_nxt;

   assign empty = (count_r == '0);
   assign wr_ready = (count_r != (AW+1)'(DEPTH));
   assign push = wr_valid && wr_ready;

   // Any word-aligned address in the alias window pops [RQ7]
   assign hit_pop = (address >= agr_pkg::POP_LO) && (address <= agr_pkg::POP_HI)
                    && (address[1:0] == 2'h0);
   // Peek only decodes in buffered mode [RQ9]
   assign hit_peek = (address == agr_pkg::PEEK_OFS) && ctrl_r[agr_pkg::CTRL_BUF];

   // A pop is taken once, at the edge the read is answered [RQ4] [RQ8]
   // Empty, overrun and suspend all hold the pointer [RQ5] [RQ6]
   assign pop = read && ack_r && hit_pop && !empty && !overrun && !suspend;
   // Refused pop while not suspended is reported, never under suspend [RQ6]
   assign pop_bad = read && ack_r && hit_pop && (empty || overrun) && !suspend;

   // Head formatting shared by both ports, done at read time [RQ3] [RQ16]
   always_comb begin
      head_word = 16'h0000;
      head_word[agr_pkg::EMPTY_BIT] = empty;                // [RQ10]
      // Bit 14 stays zero [RQ11]
      if (ctrl_r[agr_pkg::CTRL_TAG]) begin
         // Plain binary channel number, 0 to 15 [RQ12] [RQ13] [RQ14]
         head_word[agr_pkg::TAG_LSB +: agr_pkg::TAG_W] = tag_mem[rd_ptr_r];
      end
      if (ctrl_r[agr_pkg::CTRL_8BIT]) begin
         // Upper two bits zero, eight MSBs low [RQ2]
         head_word[agr_pkg::RES_W-1:0] = res_mem[rd_ptr_r] >> agr_pkg::SHIFT8;
      end else begin
         // Full ten-bit result [RQ1]
         head_word[agr_pkg::RES_W-1:0] = res_mem[rd_ptr_r];
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (hit_pop || hit_peek) begin
         rdata_nxt[15:0] = head_word;          // Peek never pops [RQ15]
      end else if (address == agr_pkg::CTRL_OFS) begin
         rdata_nxt[agr_pkg::CTRL_W-1:0] = ctrl_r;
      end else if (address == agr_pkg::IRQ_STAT_OFS) begin
         rdata_nxt[agr_pkg::EV_W-1:0] = stat_r;
      end else if (address == agr_pkg::IRQ_EN_OFS) begin
         rdata_nxt[agr_pkg::EV_W-1:0] = en_r;
      end
   end

   // Waitrequest: low in the second cycle of each access
   assign waitrequest = (read || write) && !ack_r;

   // Ack toggles once per access, so back-to-back requests each get one
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (read || write) && !ack_r;
      end
   end

   // Read data captured in the wait cycle, stands at the answering edge
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_r <= 32'h0000_0000;
      end else if (read && !ack_r) begin
         rdata_r <= rdata_nxt;
      end
   end
   assign readdata = rdata_r;

   // Control register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_r <= agr_pkg::CTRL_RST;
      end else if (write && ack_r && address == agr_pkg::CTRL_OFS) begin
         ctrl_r <= writedata[agr_pkg::CTRL_W-1:0];
      end
   end

   // Interrupt enable register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         en_r <= '0;
      end else if (write && ack_r && address == agr_pkg::IRQ_EN_OFS) begin
         en_r <= writedata[agr_pkg::EV_W-1:0];
      end
   end

   // Sticky status; a new event wins over a clear in the same cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stat_r <= '0;
      end else begin
         logic [agr_pkg::EV_W-1:0] ev;
         logic [agr_pkg::EV_W-1:0] clr;
         ev = '0;
         clr = '0;
         ev[agr_pkg::EV_POP] = pop;
         ev[agr_pkg::EV_UNDER] = pop_bad;
         if (write && ack_r && address == agr_pkg::IRQ_CLR_OFS) begin
            clr = writedata[agr_pkg::EV_W-1:0];
         end
         stat_r <= (stat_r & ~clr) | ev;
      end
   end
   assign irq = |(stat_r & en_r);

   // Storage writes from the sequencer
   always_ff @(posedge clk) begin
      if (push) begin
         res_mem[wr_ptr_r] <= wr_result;
         tag_mem[wr_ptr_r] <= wr_channel;
      end
   end

   // Pointers and count
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_ptr_r <= '0;
         wr_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + AW'(1);
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + AW'(1);   // [RQ4]
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // Named steps of a read access
   // First cycle: request up, waitrequest high
   sequence s_read_req;
      read && !ack_r;
   endsequence

   // Second cycle: waitrequest low, master takes the data
   sequence s_read_ans;
      read && ack_r && !waitrequest;
   endsequence

   // A whole read, request then answer
   sequence s_read_done;
      s_read_req ##1 s_read_ans;
   endsequence

   // Answer cycle of a pop that must be honoured
   sequence s_pop_ok;
      s_read_req ##1 (read && ack_r && address[7:5] == 3'h1 && address[1:0] == 2'h0
         && !empty && !overrun && !suspend);
   endsequence

   // A taken pop steps the output pointer by one
   a_pop_advances: assert property (@(posedge clk) disable iff (!resetn)  // [RQ4]
      pop |=> rd_ptr_r == $past(rd_ptr_r) + AW'(1))
      else $error("pop did not advance pointer");

   // A taken pop without a push removes one entry
   a_pop_removes: assert property (@(posedge clk) disable iff (!resetn)  // [RQ4]
      (pop && !push) |=> count_r == $past(count_r) - (AW+1)'(1))
      else $error("pop did not remove an entry");

   // A pop raises its sticky event
   a_pop_event: assert property (@(posedge clk) disable iff (!resetn)  // [RQ4]
      pop |=> stat_r[agr_pkg::EV_POP])
      else $error("pop event not recorded");

   // Invalid reads never move the pointer
   a_empty_holds: assert property (@(posedge clk) disable iff (!resetn)  // [RQ5]
      (read && ack_r && (empty || overrun)) |=> $stable(rd_ptr_r))
      else $error("invalid read moved pointer");

   // Empty or overrun always refuses the pop
   a_refused_nopop: assert property (@(posedge clk) disable iff (!resetn)  // [RQ5]
      (empty || overrun) |-> !pop)
      else $error("pop taken while empty or overrun");

   // A refused pop raises its sticky event
   a_refused_event: assert property (@(posedge clk) disable iff (!resetn)  // [RQ5]
      pop_bad |=> stat_r[agr_pkg::EV_UNDER])
      else $error("refused pop not recorded");

   // Suspend freezes the read side entirely
   a_suspend_holds: assert property (@(posedge clk) disable iff (!resetn)  // [RQ6]
      (suspend && !push) |=> $stable(rd_ptr_r) && $stable(count_r))
      else $error("suspend changed fifo");

   // Suspend also hides the refused-pop event
   a_suspend_quiet: assert property (@(posedge clk) disable iff (!resetn)  // [RQ6]
      suspend |-> !pop && !pop_bad)
      else $error("pop activity under suspend");

   // Every aligned alias pops when the read is valid
   a_alias_pops: assert property (@(posedge clk) disable iff (!resetn)  // [RQ7]
      s_pop_ok |-> pop)
      else $error("alias read did not pop");

   // Unaligned addresses never pop
   a_unaligned_nopop: assert property (@(posedge clk) disable iff (!resetn)  // [RQ7]
      (read && address[1:0] != 2'h0) |-> !pop)
      else $error("unaligned read popped");

   // Addresses outside the window never pop
   a_outside_nopop: assert property (@(posedge clk) disable iff (!resetn)  // [RQ7]
      (read && (address < agr_pkg::POP_LO || address > agr_pkg::POP_HI)) |-> !pop)
      else $error("read outside the window popped");

   // One access pops at most one entry, so bursts step in order
   a_pop_once: assert property (@(posedge clk) disable iff (!resetn)  // [RQ8]
      pop |=> !pop)
      else $error("one access popped twice");

   // Peek never consumes an entry
   a_peek_nopop: assert property (@(posedge clk) disable iff (!resetn)  // [RQ15]
      (read && address == agr_pkg::PEEK_OFS && !push) |=> $stable(count_r))
      else $error("peek consumed an entry");

   // Peek never moves the output pointer
   a_peek_nomove: assert property (@(posedge clk) disable iff (!resetn)  // [RQ15]
      (read && hit_peek) |=> $stable(rd_ptr_r))
      else $error("peek moved the pointer");

   // Returned flag is the one seen when the data was captured
   a_empty_flag: assert property (@(posedge clk) disable iff (!resetn)  // [RQ10]
      s_read_done |-> readdata[agr_pkg::EMPTY_BIT] == $past(empty)
      || !$past(hit_pop || hit_peek))
      else $error("empty flag wrong");

   // Flag follows the count at the head
   a_flag_count: assert property (@(posedge clk) disable iff (!resetn)  // [RQ10]
      head_word[agr_pkg::EMPTY_BIT] == (count_r == '0))
      else $error("empty flag disagrees with count");

   // Reserved bit never set
   a_bit14_zero: assert property (@(posedge clk) disable iff (!resetn)  // [RQ11]
      !readdata[14])
      else $error("bit 14 set");

   // Tag hidden while tagging is off
   a_tag_off: assert property (@(posedge clk) disable iff (!resetn)  // [RQ12]
      !ctrl_r[agr_pkg::CTRL_TAG] |-> head_word[13:10] == 4'h0)
      else $error("tag shown while disabled");

   // Tag shows the stored channel number while on
   a_tag_on: assert property (@(posedge clk) disable iff (!resetn)  // [RQ13]
      (ctrl_r[agr_pkg::CTRL_TAG] && !empty) |-> head_word[13:10] == tag_mem[rd_ptr_r])
      else $error("tag differs from stored channel");

   // Eight-bit view; empty entries hold no defined data
   a_eight_bit: assert property (@(posedge clk) disable iff (!resetn)  // [RQ2]
      (ctrl_r[agr_pkg::CTRL_8BIT] && !empty) |-> head_word[9:8] == 2'h0
      && head_word[7:0] == res_mem[rd_ptr_r][9:2])
      else $error("eight-bit format wrong");

   // Ten-bit view is the stored value unchanged
   a_ten_bit: assert property (@(posedge clk) disable iff (!resetn)  // [RQ1]
      (!ctrl_r[agr_pkg::CTRL_8BIT] && !empty) |-> head_word[9:0] == res_mem[rd_ptr_r])
      else $error("ten-bit format wrong");

   // Result ports leave the upper half word clear
   a_upper_zero: assert property (@(posedge clk) disable iff (!resetn)  // [RQ1]
      s_read_done |-> readdata[31:16] == 16'h0000 || !$past(hit_pop || hit_peek))
      else $error("upper half of result word set");

   // Both ports return the formatted head of the capture cycle
   a_same_format: assert property (@(posedge clk) disable iff (!resetn)  // [RQ16]
      s_read_done |-> !$past(hit_pop || hit_peek) || $past(empty)
      || readdata[15:0] == $past(head_word))
      else $error("port data differs from head");

   // Peek reads zero outside buffered mode
   a_peek_gated: assert property (@(posedge clk) disable iff (!resetn)  // [RQ9]
      (read && !ack_r && address == agr_pkg::PEEK_OFS && !ctrl_r[agr_pkg::CTRL_BUF])
      |=> readdata == 32'h0000_0000)
      else $error("peek visible outside buffered mode");
endmodule
`default_nettype wire

// ---- tb/agr_cpu_model.sv ----
// CPU-side model: an Avalon-MM master making single reads and writes.
// Assumes one clock; the slave answers whenever it drops waitrequest.
`timescale 1ns/10ps
`default_nettype none
module agr_cpu_model (
   // Clock
   input wire logic clk,
   // Avalon-MM master
   output logic [7:0] address,
   output logic read,
   output logic write,
   output logic [31:0] writedata,
   input wire logic waitrequest
);
   // Idle bus at time zero
   initial begin
      address = 8'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
   end
   // One transfer, held until waitrequest is low at a rising edge
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      address <= a;
      read <= !w;
      write <= w;
      writedata <= d;
      // Waitrequest is sampled at each rising edge; the request stands until it is low
      @(posedge clk);
      while (waitrequest) @(posedge clk);
      read <= 1'b0;
      write <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Bench for the group one result read ports and the interrupt.
// Assumes the CPU model drives the bus; this bench plays the sequencer.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic clk, resetn, read, write, waitrequest, irq;
   logic [7:0] address;
   logic [31:0] writedata, readdata;
   logic wr_valid, wr_ready, overrun, suspend;
   logic [9:0] wr_result;
   logic [3:0] wr_channel;
   logic [2:0] ctl;             // Bench copy of mode control
   logic [9:0] mr[$];           // Model FIFO results
   logic [3:0] mc[$];           // Model FIFO channels
   logic [31:0] eq[$], mq[$];   // Expected words and masks
   int fails, checks;
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   agr_result_fifo u_agr_result_fifo (.clk(clk), .resetn(resetn), .address(address),
      .read(read), .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .wr_valid(wr_valid), .wr_result(wr_result),
      .wr_channel(wr_channel), .wr_ready(wr_ready), .overrun(overrun),
      .suspend(suspend), .irq(irq));
   agr_cpu_model u_agr_cpu_model (.clk(clk), .address(address), .read(read),
      .write(write), .writedata(writedata), .waitrequest(waitrequest));
   function automatic logic [31:0] fmt(input logic [9:0] r, input logic [3:0] c);
      return {18'h0, ctl[2] ? c : 4'h0, ctl[1] ? {2'b00, r[9:2]} : r};
   endfunction
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   // Note the expectation first, then read
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      eq.push_back(e & m);
      mq.push_back(m);
      u_agr_cpu_model.xfer(a, 1'b0, 32'h0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      if (a == agr_pkg::CTRL_OFS) ctl = d[2:0];
      u_agr_cpu_model.xfer(a, 1'b1, d);
   endtask
   // Head entry through either port; p set means a popping read
   task automatic head(input logic [7:0] a, input logic p);
      logic ok;
      ok = mr.size() > 0;
      if (!ok) rd(a, 32'h8000, 32'hffffc000);
      else rd(a, fmt(mr[0], mc[0]), 32'hffffffff);
      if (ok && p && !overrun && !suspend) begin
         void'(mr.pop_front());
         void'(mc.pop_front());
      end
   endtask
   // Push n random results, channel number counting up
   task automatic fill(input int n);
      logic [9:0] r;
      for (int i = 0; i < n; i++) begin
         r = 10'($urandom);
         wr_valid <= 1'b1;
         wr_result <= r;
         wr_channel <= 4'(i);
         mr.push_back(r);
         mc.push_back(4'(i));
         @(posedge clk);
      end
      wr_valid <= 1'b0;
      // Ready drops only once every entry is taken
      @(negedge clk);
      chk("wr_ready", {31'h0, wr_ready}, {31'h0, mr.size() < 16});
   endtask
   task automatic irq_is(input logic v);
      @(negedge clk);
      chk("irq", {31'h0, irq}, {31'h0, v});
   endtask
   task automatic close_out;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Each answer is matched to the oldest note
   always @(negedge clk) begin
      if (read && !waitrequest && eq.size() > 0)
         chk("readdata", readdata & mq.pop_front(), eq.pop_front());
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      close_out();
   end
   initial begin
      void'($urandom(32'h4ad5));
      resetn = 1'b0;
      wr_valid = 1'b0;
      wr_result = 10'h0;
      wr_channel = 4'h0;
      overrun = 1'b0;
      suspend = 1'b0;
      ctl = 3'h1;
      fails = 0;
      checks = 0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      // Empty pop refused, event masked, enabled, cleared; unmapped read
      head(agr_pkg::POP_LO, 1'b1);
      rd(agr_pkg::IRQ_STAT_OFS, 32'h2, 32'hffffffff);
      irq_is(1'b0);
      wr(agr_pkg::IRQ_EN_OFS, 32'h2);
      irq_is(1'b1);
      wr(agr_pkg::IRQ_CLR_OFS, 32'h3);
      irq_is(1'b0);
      rd(8'h21, 32'h0, 32'hffffffff);
      $display("test 1 done");
      // Full FIFO drained through every alias, peeking before each pop
      fill(16);
      for (int j = 0; j < 2; j++) begin
         wr(agr_pkg::CTRL_OFS, j ? 32'h7 : 32'h1);
         for (int k = 0; k < 8; k++) begin
            head(agr_pkg::PEEK_OFS, 1'b0);
            head(8'(agr_pkg::POP_LO + 4 * k), 1'b1);
         end
         overrun <= !j;
         suspend <= j;
         @(posedge clk);
         head(agr_pkg::POP_LO, 1'b1);
         overrun <= 1'b0;
         suspend <= 1'b0;
         @(posedge clk);
      end
      head(agr_pkg::POP_LO, 1'b1);
      $display("test 2 done");
      // Peek hidden outside buffered mode; pop event raises irq
      wr(agr_pkg::CTRL_OFS, 32'h0);
      fill(1);
      rd(agr_pkg::PEEK_OFS, 32'h0, 32'hffffffff);
      wr(agr_pkg::CTRL_OFS, 32'h1);
      head(agr_pkg::POP_LO, 1'b1);
      wr(agr_pkg::IRQ_EN_OFS, 32'h1);
      irq_is(1'b1);
      wr(agr_pkg::IRQ_CLR_OFS, 32'h1);
      irq_is(1'b0);
      $display("test 3 done");
      close_out();
   end
endmodule
`default_nettype wire
